// ==== pkg/ddop_pkg.sv ====
`default_nettype none
package ddop_pkg;
  // object address on the process data channel
  localparam logic [15:0] OBJ_INDEX = 16'h2522;
  localparam int OBJ_W = 16;
  localparam int NUM_PORTS = 3;
  // stored part of the object: port bits plus the reserved bits
  localparam int KEEP_W = 8;
  localparam int PORT_LSB = 0;
  localparam int RSVD_LSB = 3;
  localparam int RSVD_MSB = 7;
  localparam int MFR_LSB = 8;
  localparam int MFR_MSB = 15;
  localparam logic [KEEP_W-1:0] OBJ_RESET = 8'h00;
  localparam logic [NUM_PORTS-1:0] PORT_RESET = 3'h0;
  localparam logic [OBJ_W-KEEP_W-1:0] MFR_READ = 8'h00;
  localparam logic [OBJ_W-1:0] RD_UNMAPPED = 16'h0000;

  // cyclic write of one object
  typedef struct packed {
    logic valid;
    logic [OBJ_W-1:0] index;
    logic [OBJ_W-1:0] data;
  } ddop_wr_t;

  // read-back request of one object
  typedef struct packed {
    logic valid;
    logic [OBJ_W-1:0] index;
  } ddop_rd_t;

  // whole state of the port block
  typedef struct packed {
    logic [KEEP_W-1:0] obj;
    logic [NUM_PORTS-1:0] port;
    logic rd_valid;
    logic rd_err;
    logic [OBJ_W-1:0] rd_data;
  } ddop_state_t;
endpackage
`default_nettype wire

// ==== rtl/ddop_sel.sv ====
`timescale 1ns/1ps
`default_nettype none
// picks between the commanded level and the allocated function of one port
module ddop_sel (
  input wire logic cmd_bit,
  input wire logic direct_mode,
  input wire logic func_bit,
  output logic port_level
);
  assign port_level = direct_mode ? cmd_bit : func_bit;
endmodule
`default_nettype wire

// ==== rtl/ddop_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddop_port #(
  parameter int ALLOC_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ddop_pkg::ddop_wr_t pd_wr,
  input wire ddop_pkg::ddop_rd_t pd_rd,
  input wire logic [ALLOC_W-1:0] output_allocation_param_a,
  input wire logic [ALLOC_W-1:0] output_allocation_param_b,
  input wire logic [ALLOC_W-1:0] output_allocation_param_c,
  input wire logic [ddop_pkg::NUM_PORTS-1:0] alloc_func,
  output logic general_output_port_a,
  output logic general_output_port_b,
  output logic general_output_port_c,
  output logic [ddop_pkg::OBJ_W-1:0] general_output_command_q,
  output logic rd_valid_q,
  output logic rd_err_q,
  output logic [ddop_pkg::OBJ_W-1:0] rd_data_q
);

  // same address test serves writes and reads
  function automatic logic index_hit(input logic [ddop_pkg::OBJ_W-1:0] idx);
    index_hit = (idx == ddop_pkg::OBJ_INDEX);
  endfunction

  // zero test is shared by all three allocation inputs
  function automatic logic alloc_zero(input logic [ALLOC_W-1:0] p);
    alloc_zero = (p == '0);
  endfunction

  ddop_pkg::ddop_state_t state_q;
  ddop_pkg::ddop_state_t state_d;
  logic direct_mode;
  logic wr_hit;
  logic rd_hit;
  logic [ddop_pkg::NUM_PORTS-1:0] port_next;
  logic [ddop_pkg::KEEP_W-1:0] obj_next;

  assign direct_mode = alloc_zero(output_allocation_param_a)
                     & alloc_zero(output_allocation_param_b)
                     & alloc_zero(output_allocation_param_c);
  assign wr_hit = pd_wr.valid & index_hit(pd_wr.index);
  assign rd_hit = pd_rd.valid & index_hit(pd_rd.index);

  // next object value, kept out of state_d so the port selectors do not
  // feed back into the process that fills the state copy
  assign obj_next = wr_hit ? pd_wr.data[ddop_pkg::KEEP_W-1:0] : state_q.obj;

  // one selector per port; selection uses the object's next value so a
  // write reaches the pins at the same edge as it reaches the object
  genvar gi;
  generate
    for (gi = 0; gi < ddop_pkg::NUM_PORTS; gi++) begin : g_port
      ddop_sel u_sel (
        .cmd_bit(obj_next[ddop_pkg::PORT_LSB + gi]),
        .direct_mode(direct_mode),
        .func_bit(alloc_func[gi]),
        .port_level(port_next[gi])
      );
    end
  endgenerate

  // next state
  always_comb begin
    state_d = state_q;
    state_d.obj = obj_next;
    state_d.port = port_next;
    // read answers one cycle later; a write in the same cycle is not seen
    state_d.rd_valid = pd_rd.valid;
    state_d.rd_err = pd_rd.valid & ~rd_hit;
    if (rd_hit) begin
      state_d.rd_data = {ddop_pkg::MFR_READ, state_q.obj};
    end else begin
      state_d.rd_data = ddop_pkg::RD_UNMAPPED;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '{obj: ddop_pkg::OBJ_RESET,
                   port: ddop_pkg::PORT_RESET,
                   rd_valid: 1'b0,
                   rd_err: 1'b0,
                   rd_data: ddop_pkg::RD_UNMAPPED};
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state flops
  assign general_output_port_a = state_q.port[0];
  assign general_output_port_b = state_q.port[1];
  assign general_output_port_c = state_q.port[2];
  assign general_output_command_q = {ddop_pkg::MFR_READ, state_q.obj};
  assign rd_valid_q = state_q.rd_valid;
  assign rd_err_q = state_q.rd_err;
  assign rd_data_q = state_q.rd_data;

  // checks on the driven outputs
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_write_stores: assert property (
    wr_hit |=> general_output_command_q[ddop_pkg::KEEP_W-1:0]
               == $past(pd_wr.data[ddop_pkg::KEEP_W-1:0]))
    else $error("object write not stored");

  a_port_follows_cmd: assert property (
    (wr_hit && direct_mode) |=> general_output_port_a
      == $past(pd_wr.data[ddop_pkg::PORT_LSB]))
    else $error("port a does not follow command bit");

  a_port_b_cmd: assert property (
    (wr_hit && direct_mode) |=> general_output_port_b
      == $past(pd_wr.data[ddop_pkg::PORT_LSB + 1]))
    else $error("port b does not follow command bit");

  a_port_c_cmd: assert property (
    (wr_hit && direct_mode) |=> general_output_port_c
      == $past(pd_wr.data[ddop_pkg::PORT_LSB + 2]))
    else $error("port c does not follow command bit");

  a_cmd_off_port: assert property (
    (wr_hit && direct_mode && !pd_wr.data[ddop_pkg::PORT_LSB])
      |=> !general_output_port_a)
    else $error("off command left port a on");

  a_high_byte_zero: assert property (
    (general_output_command_q[ddop_pkg::MFR_MSB:ddop_pkg::MFR_LSB]
      == ddop_pkg::MFR_READ)
    && (!rd_valid_q
        || (rd_data_q[ddop_pkg::MFR_MSB:ddop_pkg::MFR_LSB]
            == ddop_pkg::MFR_READ)))
    else $error("high byte of object not ignored");

  a_write_low_only: assert property (
    wr_hit |=> general_output_command_q == {ddop_pkg::MFR_READ,
      $past(pd_wr.data[ddop_pkg::KEEP_W-1:0])})
    else $error("write high byte reached the object");

  // reserved bits are stored and read back, but drive no port
  a_rsvd_stored: assert property (
    wr_hit |=>
      general_output_command_q[ddop_pkg::RSVD_MSB:ddop_pkg::RSVD_LSB]
      == $past(pd_wr.data[ddop_pkg::RSVD_MSB:ddop_pkg::RSVD_LSB]))
    else $error("reserved bits not kept");

  a_alloc_func_out: assert property (
    !direct_mode |=> general_output_port_c == $past(alloc_func[2]))
    else $error("allocated function not on port c");

  // any nonzero allocation hands every port to its function; these
  // read the allocation inputs directly rather than the mode decode
  a_alloc_func_a: assert property (
    (output_allocation_param_a != '0 || output_allocation_param_b != '0
     || output_allocation_param_c != '0)
      |=> general_output_port_a == $past(alloc_func[0]))
    else $error("allocated function not on port a");

  a_alloc_func_b: assert property (
    (output_allocation_param_a != '0 || output_allocation_param_b != '0
     || output_allocation_param_c != '0)
      |=> general_output_port_b == $past(alloc_func[1]))
    else $error("allocated function not on port b");

  a_alloc_raw_c: assert property (
    (output_allocation_param_a != '0 || output_allocation_param_b != '0
     || output_allocation_param_c != '0)
      |=> general_output_port_c == $past(alloc_func[2]))
    else $error("port c not handed to its function");

  a_direct_hold: assert property (
    (direct_mode && !wr_hit) |=>
      {general_output_port_c, general_output_port_b}
      == $past(general_output_command_q[2:1]))
    else $error("ports b and c do not follow object");

  a_direct_port_a: assert property (
    (direct_mode && !wr_hit) |=> general_output_port_a
      == $past(general_output_command_q[ddop_pkg::PORT_LSB]))
    else $error("port a does not follow object");

  a_no_write_hold: assert property (
    !wr_hit |=> $stable(general_output_command_q))
    else $error("object changed without write");

  // the reset check must not be switched off by reset itself
  a_reset_clear: assert property (
    @(posedge core_clk) disable iff (1'b0)
    rst |=> (general_output_command_q
             == {ddop_pkg::MFR_READ, ddop_pkg::OBJ_RESET})
            && ({general_output_port_c, general_output_port_b,
                 general_output_port_a} == ddop_pkg::PORT_RESET)
            && !rd_valid_q && !rd_err_q)
    else $error("reset did not clear object and ports");

  a_unmapped_read: assert property (
    (pd_rd.valid && !rd_hit) |=> rd_valid_q && rd_err_q
                                 && rd_data_q == ddop_pkg::RD_UNMAPPED)
    else $error("unmapped read not flagged");

  // read side: one answer per strobe, error only with an answer
  a_read_mapped: assert property (
    rd_hit |=> rd_valid_q && !rd_err_q
               && rd_data_q == $past(general_output_command_q))
    else $error("mapped read returned wrong value");

  a_read_pulse: assert property (
    !pd_rd.valid |=> !rd_valid_q && !rd_err_q)
    else $error("read answer without request");

  a_err_with_valid: assert property (
    rd_err_q |-> rd_valid_q)
    else $error("read error flag without answer");

  a_unmapped_write: assert property (
    (pd_wr.valid && (pd_wr.index != ddop_pkg::OBJ_INDEX))
      |=> $stable(general_output_command_q))
    else $error("unmapped write changed the object");

endmodule
`default_nettype wire

// ==== verif/ddop_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// network controller: one object write or read-back per call
module ddop_ctrl_model (
  input wire logic core_clk,
  output var ddop_pkg::ddop_wr_t pd_wr,
  output var ddop_pkg::ddop_rd_t pd_rd
);
  // idle bus at time zero
  initial begin
    pd_wr = '0;
    pd_rd = '0;
  end
  // released fields carry ~idx and ~d, so a reserved bit set in d shows 0 before and after release
  // reserved bits kept clear
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge core_clk);
    pd_wr <= '{1'b1, idx, d & 16'hFF07};
    @(posedge core_clk);
    pd_wr <= '{1'b0, ~idx, ~d};
    #1;
  endtask
  // read strobe held for exactly one taking edge
  task automatic rd(input logic [15:0] idx);
    @(posedge core_clk);
    pd_rd <= '{1'b1, idx};
    @(posedge core_clk);
    pd_rd <= '{1'b0, ~idx};
    #1;
  endtask
endmodule
`default_nettype wire

// ==== verif/test_drive_digital_output_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_drive_digital_output_port;
  logic core_clk;
  logic rst;
  logic [7:0] al_a, al_b, al_c;
  logic [2:0] al_func, ports;
  ddop_pkg::ddop_wr_t pd_wr;
  ddop_pkg::ddop_rd_t pd_rd;
  logic [15:0] cmd, rd_data;
  logic rd_valid, rd_err;
  int error_cnt = 0;
  int comparisons = 0;
  ddop_ctrl_model i_ddop_ctrl_model (.core_clk(core_clk), .pd_wr(pd_wr),
    .pd_rd(pd_rd));
  ddop_port #(.ALLOC_W(8)) i_ddop_port (.core_clk(core_clk), .rst(rst),
    .pd_wr(pd_wr), .pd_rd(pd_rd), .output_allocation_param_a(al_a),
    .output_allocation_param_b(al_b), .output_allocation_param_c(al_c),
    .alloc_func(al_func), .general_output_port_a(ports[0]),
    .general_output_port_b(ports[1]), .general_output_port_c(ports[2]),
    .general_output_command_q(cmd), .rd_valid_q(rd_valid),
    .rd_err_q(rd_err), .rd_data_q(rd_data));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one read-back with its answer checked
  task automatic rdchk(input logic [15:0] idx, input logic err,
    input logic [15:0] exp);
    i_ddop_ctrl_model.rd(idx);
    chk({14'h0, rd_valid, rd_err}, {14'h0, 1'b1, err});
    chk(rd_data, exp);
  endtask
  // verdict
  task automatic end_sim;
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // hang guard, far beyond the ~50 cycles the tests need
  initial begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    end_sim();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {al_a, al_b, al_c, al_func} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({13'h0, ports}, 16'h0000);
    rdchk(16'h2522, 1'b0, 16'h0000);
    for (int v = 0; v < 8; v++) begin
      i_ddop_ctrl_model.wr(16'h2522, 16'hA500 | 16'(v));
      chk({13'h0, ports}, 16'(v));
      rdchk(16'h2522, 1'b0, 16'(v));
    end
    i_ddop_ctrl_model.wr(16'h2521, 16'h0002);
    chk(cmd, 16'h0007);
    rdchk(16'h2523, 1'b1, 16'h0000);
    // each nonzero allocation alone hands the ports to their function
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      al_a <= (i == 0) ? 8'h01 : 8'h00;
      al_b <= (i == 1) ? 8'h80 : 8'h00;
      al_c <= (i == 2) ? 8'hFF : 8'h00;
      al_func <= 3'(i + 2);
      @(posedge core_clk);
      #1;
      chk({13'h0, ports}, 16'(i + 2));
    end
    @(posedge core_clk);
    {al_a, al_b, al_c} <= '0;
    @(posedge core_clk);
    #1;
    chk({13'h0, ports}, 16'h0007);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk({cmd[12:0], ports}, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
